// *** rtl/sio_tx_pkg.sv ***
// Purpose: Shared constants for the synchronous serial transmit control.
// Assumes: Core clock of 40 MHz.
// Notes: Mode 00 is the forced stop code.
package sio_tx_pkg;
    localparam int CORE_CLK_MHZ = 40;
    localparam int DATA_BITS = 8;
    localparam int EDGE_CNT_W = 4;
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] BUF_RESET = 8'h00;
    localparam logic [7:0] SHIFT_RESET = 8'hff;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Half period of the internally generated serial clock
    localparam int SCLK_HALF_NS = 200;
    localparam int SCLK_HALF_CYC_INT = (SCLK_HALF_NS * CORE_CLK_MHZ) / 1000;
    localparam logic [7:0] SCLK_HALF_CYC =
        8'(SCLK_HALF_CYC_INT < 1 ? 1 : SCLK_HALF_CYC_INT);
endpackage : sio_tx_pkg

// *** rtl/sync_two_ff.sv ***
// Purpose: Two flip-flop synchroniser for a vector of independent or gray bits.
// Assumes: Input bits change at most one at a time when used as a word.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : sync_two_ff

// *** rtl/sync_serial_transmit_ctrl.sv ***
// Purpose: Transmit control of an 8-bit clocked synchronous serial channel.
// Assumes: Software strobes are single core_clk pulses; linkClk is the peer's clock.
// Notes: External clock edges are counted on linkClk and crossed as a gray count.
`timescale 1ns/1ps
module sync_serial_transmit_ctrl (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic linkClk,
    input wire logic controlWrite,
    input wire logic [1:0] controlModeIn,
    input wire logic controlRunIn,
    input wire logic controlExtClkIn,
    input wire logic bufWrite,
    input wire logic [7:0] bufData,
    input wire logic statusRead,
    output logic transferRun,
    output logic [1:0] transferMode,
    output logic shiftActive,
    output logic bufFull,
    output logic underrunError,
    output logic operationActive,
    output logic serialIrq,
    output logic serialClkOut,
    output logic serialClkOe,
    output logic serialDataOut
);
    // Link domain: count of peer clock edges, gray coded
    logic [sio_tx_pkg::EDGE_CNT_W-1:0] linkBin_r;
    logic [sio_tx_pkg::EDGE_CNT_W-1:0] linkGray_r;
    logic [sio_tx_pkg::EDGE_CNT_W-1:0] linkBinNxt;

    assign linkBinNxt = linkBin_r + 4'h1;

    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            linkBin_r <= '0;
            linkGray_r <= '0;
        end else begin
            linkBin_r <= linkBinNxt;
            linkGray_r <= linkBinNxt ^ (linkBinNxt >> 1);
        end
    end

    // Core domain
    logic [sio_tx_pkg::EDGE_CNT_W-1:0] grayCore;
    logic [sio_tx_pkg::EDGE_CNT_W-1:0] binCore;
    logic [sio_tx_pkg::EDGE_CNT_W-1:0] seen_r;

    sync_two_ff #(.W(sio_tx_pkg::EDGE_CNT_W)) u_edge_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .din(linkGray_r),
        .dout(grayCore)
    );

    always_comb begin
        binCore[sio_tx_pkg::EDGE_CNT_W-1] = grayCore[sio_tx_pkg::EDGE_CNT_W-1];
        for (int i = sio_tx_pkg::EDGE_CNT_W - 2; i >= 0; i--) begin
            binCore[i] = binCore[i+1] ^ grayCore[i];
        end
    end

    logic extClk_r;
    logic stopPending_r;
    logic lastBit_r;
    logic dataRelease_r;
    logic [7:0] txBuf_r;
    logic [7:0] shift_r;
    logic [2:0] bitCnt_r;
    logic [7:0] div_r;

    // One peer edge consumed per core cycle; link is slower than core
    wire extEdge = (binCore != seen_r);
    wire extTick = extEdge && extClk_r;
    wire divDone = (div_r == sio_tx_pkg::SCLK_HALF_CYC - 8'h01);
    // Internal clock: shift on falling half, peer samples on rising
    wire intTick = !extClk_r && shiftActive && divDone && serialClkOut;
    wire intRise = !extClk_r && shiftActive && divDone && !serialClkOut;
    wire bitTick = shiftActive && (extTick || intTick);
    // Internal byte ends on the rise that samples bit 0, not on its fall
    wire byteEnd = extClk_r ? (extTick && shiftActive && bitCnt_r == sio_tx_pkg::LAST_BIT)
                            : (intRise && lastBit_r);
    wire forceStop = controlWrite && (controlModeIn == sio_tx_pkg::MODE_STOP);
    wire runStart = controlWrite && !forceStop && controlRunIn && !transferRun;
    wire runStop = controlWrite && !forceStop && !controlRunIn && transferRun;
    wire stopNow = runStop && !shiftActive;
    wire stopAfter = byteEnd && (stopPending_r || runStop);
    wire chainNext = byteEnd && !stopAfter && bufFull;
    wire pauseByte = byteEnd && !stopAfter && !bufFull;
    wire restart = operationActive && !shiftActive && !stopNow
                   && (bufWrite || (runStart && bufFull));
    wire startFromIdle = runStart && bufFull;
    wire underrunHit = extTick && operationActive && !shiftActive && !bufWrite;
    wire [7:0] loadData = bufWrite ? bufData : txBuf_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_r <= '0;
        end else if (extEdge) begin
            seen_r <= seen_r + 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transferRun <= 1'b0;
            transferMode <= sio_tx_pkg::MODE_RESET;
            extClk_r <= 1'b0;
            operationActive <= 1'b0;
            stopPending_r <= 1'b0;
        end else if (forceStop) begin
            transferRun <= 1'b0;
            transferMode <= sio_tx_pkg::MODE_STOP;
            operationActive <= 1'b0;
            stopPending_r <= 1'b0;
        end else begin
            if (controlWrite) begin
                transferRun <= controlRunIn;
                transferMode <= controlModeIn;
                if (!operationActive) begin
                    extClk_r <= controlExtClkIn;
                end
            end
            if (runStart) begin
                operationActive <= 1'b1;
            end else if (stopNow || stopAfter) begin
                operationActive <= 1'b0;
            end
            if (runStop && shiftActive && !byteEnd) begin
                stopPending_r <= 1'b1;
            end else if (stopAfter) begin
                stopPending_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txBuf_r <= sio_tx_pkg::BUF_RESET;
            bufFull <= 1'b0;
        end else if (forceStop || stopNow || stopAfter) begin
            bufFull <= 1'b0;
        end else if (bufWrite && !restart) begin
            txBuf_r <= bufData;
            bufFull <= 1'b1;
        end else if (chainNext || restart || startFromIdle) begin
            bufFull <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= sio_tx_pkg::SHIFT_RESET;
            bitCnt_r <= '0;
            shiftActive <= 1'b0;
            lastBit_r <= 1'b0;
        end else if (forceStop || stopAfter) begin
            shiftActive <= 1'b0;
            bitCnt_r <= '0;
            lastBit_r <= 1'b0;
        end else if (chainNext) begin
            shift_r <= txBuf_r;
            bitCnt_r <= '0;
            shiftActive <= 1'b1;
            lastBit_r <= 1'b0;
        end else if (restart || startFromIdle) begin
            shift_r <= loadData;
            bitCnt_r <= '0;
            shiftActive <= 1'b1;
            lastBit_r <= 1'b0;
        end else if (pauseByte) begin
            shiftActive <= 1'b0;
            bitCnt_r <= '0;
            lastBit_r <= 1'b0;
        end else if (bitTick) begin
            shift_r <= {shift_r[6:0], shift_r[7]};
            bitCnt_r <= bitCnt_r + 3'h1;
            // LAST_BIT only reached here on internal clock: external bit 8 ends the byte above
            lastBit_r <= (bitCnt_r == sio_tx_pkg::LAST_BIT);
        end else if (underrunHit) begin
            // Stale contents rotate out: the undefined value
            shift_r <= {shift_r[6:0], shift_r[7]};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            underrunError <= 1'b0;
        end else if (forceStop) begin
            underrunError <= 1'b0;
        end else if (underrunHit) begin
            // Set wins over the read clear
            underrunError <= 1'b1;
        end else if (statusRead) begin
            underrunError <= 1'b0;
        end
    end

    // Data pin: last bit holds on external clock between bytes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serialDataOut <= 1'b1;
            dataRelease_r <= 1'b0;
        end else begin
            // Release a cycle late so bit 0 outlives its sampling rise
            dataRelease_r <= (stopNow || stopAfter) && !extClk_r && !forceStop;
            if (forceStop || dataRelease_r) begin
                serialDataOut <= 1'b1;
            end else if (bitTick || underrunHit) begin
                serialDataOut <= shift_r[7];
            end
        end
    end

    // Internal serial clock generator, idle high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
            serialClkOut <= 1'b1;
        end else if (forceStop || extClk_r || !shiftActive) begin
            div_r <= '0;
            serialClkOut <= 1'b1;
        end else if (divDone) begin
            div_r <= '0;
            serialClkOut <= !serialClkOut;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serialClkOe <= 1'b0;
            serialIrq <= 1'b0;
        end else begin
            serialClkOe <= !extClk_r && operationActive && !forceStop;
            // Irq pulse at restart, start from idle, chained byte and each run-bit stop; none at a mode 00 forced stop
            serialIrq <= !forceStop && (restart || startFromIdle || chainNext
                         || stopNow || stopAfter);
        end
    end
endmodule : sync_serial_transmit_ctrl

// *** testbench/sio_tx_checker_asserts.sv ***
// Purpose: Concurrent checks on the transmit control ports.
// Assumes: All flags live in the core_clk domain.
// Notes: A forced stop may legally cut a byte short.
`timescale 1ns/1ps
module sio_tx_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic controlWrite,
    input wire logic [1:0] controlModeIn,
    input wire logic controlRunIn,
    input wire logic bufWrite,
    input wire logic statusRead,
    input wire logic transferRun,
    input wire logic shiftActive,
    input wire logic bufFull,
    input wire logic underrunError,
    input wire logic operationActive,
    input wire logic serialIrq,
    input wire logic serialClkOut,
    input wire logic serialClkOe,
    input wire logic serialDataOut
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire forceStop = controlWrite && controlModeIn == sio_tx_pkg::MODE_STOP;
    wire runOff = controlWrite && !controlRunIn && !forceStop;
    a_restart_irq: assert property (bufWrite && operationActive && !shiftActive && !controlWrite
        |=> shiftActive && serialIrq) else $error("restart without shift or irq");
    a_underrun_cause: assert property ($rose(underrunError)
        |-> operationActive && !shiftActive && !serialClkOe) else $error("underrun out of place");
    a_underrun_clear: assert property ($fell(underrunError) |-> $past(statusRead) || $past(forceStop))
        else $error("underrun cleared without cause");
    a_chain_move: assert property ($fell(bufFull) && operationActive |-> shiftActive && serialIrq)
        else $error("chained byte not started");
    a_idle_stop: assert property (runOff && operationActive && !shiftActive && !bufWrite
        |=> !operationActive && serialIrq) else $error("idle stop late");
    a_reserved_stop: assert property (runOff && shiftActive ##1 shiftActive |-> operationActive)
        else $error("stop cut the byte");
    a_stop_flags: assert property ($fell(operationActive)
        |-> !shiftActive && !bufFull ##1 (serialDataOut || !$past(serialClkOe, 2)))
        else $error("stop left flags or data wrong");
    a_forced_stop: assert property (forceStop |=> !transferRun && !shiftActive && !bufFull
        && !underrunError && !operationActive && serialDataOut && serialClkOut)
        else $error("forced stop incomplete");
    a_shift_hold: assert property ($rose(shiftActive) |-> shiftActive[*8] or ##[0:7] forceStop)
        else $error("shift dropped early");
endmodule : sio_tx_checker
bind sync_serial_transmit_ctrl sio_tx_checker sio_tx_checker_i (.core_clk(core_clk), .rst_n(rst_n),
    .controlWrite(controlWrite), .controlModeIn(controlModeIn), .controlRunIn(controlRunIn),
    .bufWrite(bufWrite), .statusRead(statusRead), .transferRun(transferRun),
    .shiftActive(shiftActive), .bufFull(bufFull), .underrunError(underrunError),
    .operationActive(operationActive), .serialIrq(serialIrq), .serialClkOut(serialClkOut),
    .serialClkOe(serialClkOe), .serialDataOut(serialDataOut));

// *** testbench/sio_peer_model.sv ***
// Purpose: External peer that clocks the serial channel.
// Assumes: Peer clock period of 32 ns.
// Notes: Clock stands low between bursts, as a real peer would.
`timescale 1ns/1ps
module sio_peer_model (
    output logic linkClk
);
    initial linkClk = 1'b0;
    task automatic burst(input int n);
        #7;
        repeat (n) begin
            #16 linkClk = 1'b1;
            #16 linkClk = 1'b0;
        end
    endtask : burst
endmodule : sio_peer_model

// *** testbench/test_sync_serial_transmit_ctrl.sv ***
// Purpose: Self-checking run of the serial transmit control.
// Assumes: Inputs change on the falling core clock edge.
// Notes: Bits are taken at each rising serial clock while it is driven.
`timescale 1ns/1ps
module test_sync_serial_transmit_ctrl;
    logic core_clk, rst_n, linkClk, controlWrite, controlRunIn, controlExtClkIn, bufWrite;
    logic statusRead, transferRun, shiftActive, bufFull, underrunError, operationActive;
    logic serialIrq, serialClkOut, serialClkOe, serialDataOut, prevClk, prevOe;
    logic [1:0] controlModeIn, transferMode;
    logic [7:0] bufData;
    logic [15:0] rxBits;
    int miscompares, compares, irqCount;
    sio_peer_model sio_peer_model_i (.linkClk(linkClk));
    sync_serial_transmit_ctrl sync_serial_transmit_ctrl_i (.core_clk(core_clk), .rst_n(rst_n),
        .linkClk(linkClk), .controlWrite(controlWrite), .controlModeIn(controlModeIn),
        .controlRunIn(controlRunIn), .controlExtClkIn(controlExtClkIn), .bufWrite(bufWrite),
        .bufData(bufData), .statusRead(statusRead), .transferRun(transferRun),
        .transferMode(transferMode), .shiftActive(shiftActive), .bufFull(bufFull),
        .underrunError(underrunError), .operationActive(operationActive), .serialIrq(serialIrq),
        .serialClkOut(serialClkOut), .serialClkOe(serialClkOe), .serialDataOut(serialDataOut));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (serialIrq === 1'b1) irqCount++;
        if (serialClkOut && !prevClk && prevOe) rxBits <= {rxBits[14:0], serialDataOut};
        prevClk <= serialClkOut;
        prevOe <= serialClkOe;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // Strobes drop for a full cycle so no signal is set twice in one step
    task automatic drive(input logic [2:0] stb, input logic [1:0] m, input logic r,
        input logic e, input logic [7:0] d);
        {controlWrite, bufWrite, statusRead} = stb;
        {controlModeIn, controlRunIn, controlExtClkIn, bufData} = {m, r, e, d};
        @(negedge core_clk);
        {controlWrite, bufWrite, statusRead} = 3'h0;
        @(negedge core_clk);
    endtask : drive
    task automatic wait_low(input bit op);
        int i;
        for (i = 0; i < 800; i++) begin
            if (!(op ? operationActive : shiftActive)) break;
            @(negedge core_clk);
        end
        if (i == 800) begin
            miscompares++;
            final_report();
        end
    endtask : wait_low
    initial begin
        {rst_n, controlWrite, bufWrite, statusRead, controlRunIn, controlExtClkIn} = 6'h00;
        {controlModeIn, bufData, prevClk, prevOe} = 12'h002;
        {miscompares, compares, irqCount} = {32'h0, 32'h0, 32'h0};
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        chk("resetPins", {serialDataOut, serialClkOut, serialClkOe}, 3'h6);
        drive(3'h4, 2'h1, 1'b1, 1'b0, 8'h00);
        drive(3'h2, 2'h1, 1'b1, 1'b0, 8'ha5);
        drive(3'h2, 2'h1, 1'b1, 1'b0, 8'h3c);
        chk("bufFull", bufFull, 1'b1);
        wait_low(1'b0);
        repeat (10) @(negedge core_clk);
        chk("rxBits", rxBits, 16'ha53c);
        chk("irqCount", 16'(irqCount), 16'h2);
        drive(3'h2, 2'h1, 1'b1, 1'b0, 8'h7e);
        drive(3'h4, 2'h1, 1'b0, 1'b0, 8'h00);
        chk("runHold", operationActive, 1'b1);
        wait_low(1'b1);
        repeat (10) @(negedge core_clk);
        chk("rxByte", rxBits[7:0], 8'h7e);
        chk("dataHigh", serialDataOut, 1'b1);
        chk("irqCount", 16'(irqCount), 16'h4);
        drive(3'h4, 2'h1, 1'b1, 1'b0, 8'h00);
        drive(3'h4, 2'h1, 1'b0, 1'b0, 8'h00);
        chk("idleStop", {operationActive, irqCount[3:0]}, 5'h05);
        // Byte loaded while stopped goes out when run is set
        drive(3'h2, 2'h1, 1'b0, 1'b0, 8'hc3);
        drive(3'h4, 2'h1, 1'b1, 1'b0, 8'h00);
        chk("startFull", {bufFull, shiftActive}, 2'h1);
        wait_low(1'b0);
        repeat (10) @(negedge core_clk);
        chk("rxStart", rxBits[7:0], 8'hc3);
        drive(3'h4, 2'h1, 1'b1, 1'b0, 8'h00);
        drive(3'h2, 2'h1, 1'b1, 1'b0, 8'h00);
        repeat (20) @(negedge core_clk);
        drive(3'h4, 2'h0, 1'b1, 1'b0, 8'h00);
        chk("forceStop", {transferRun, shiftActive, serialDataOut, serialClkOut, transferMode},
            6'h0c);
        drive(3'h4, 2'h1, 1'b1, 1'b1, 8'h00);
        drive(3'h2, 2'h1, 1'b1, 1'b1, 8'h5e);
        sio_peer_model_i.burst(8);
        wait_low(1'b0);
        repeat (8) @(negedge core_clk);
        chk("extHold", {underrunError, serialDataOut}, 2'h0);
        sio_peer_model_i.burst(2);
        repeat (8) @(negedge core_clk);
        chk("underrun", underrunError, 1'b1);
        // No buffer load while the stale value goes out
        drive(3'h1, 2'h1, 1'b1, 1'b1, 8'h00);
        chk("underrunClr", underrunError, 1'b0);
        drive(3'h4, 2'h0, 1'b0, 1'b0, 8'h00);
        chk("stopHigh", serialDataOut, 1'b1);
        // Stop on external clock keeps bit 0; mode 00 then lifts the pin
        drive(3'h4, 2'h1, 1'b1, 1'b1, 8'h00);
        drive(3'h2, 2'h1, 1'b1, 1'b1, 8'h5e);
        sio_peer_model_i.burst(8);
        wait_low(1'b0);
        repeat (8) @(negedge core_clk);
        drive(3'h4, 2'h1, 1'b0, 1'b1, 8'h00);
        chk("extStopHold", {operationActive, serialDataOut}, 2'h0);
        drive(3'h4, 2'h0, 1'b0, 1'b1, 8'h00);
        chk("modeZeroHigh", serialDataOut, 1'b1);
        final_report();
    end
endmodule : test_sync_serial_transmit_ctrl
